// ### core/pco_clock_output.sv
`default_nettype none
module pco_clock_output (
	// Clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// AXI4-Lite write address
	input  wire logic [pco_pkg::ADDR_W-1:0]  awaddr,
	input  wire logic [2:0]                  awprot,
	input  wire logic                        awvalid,
	output logic                             awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	// AXI4-Lite write response
	output logic      [1:0]                  bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	// AXI4-Lite read address
	input  wire logic [pco_pkg::ADDR_W-1:0]  araddr,
	input  wire logic [2:0]                  arprot,
	input  wire logic                        arvalid,
	output logic                             arready,
	// AXI4-Lite read data
	output logic      [31:0]                 rdata,
	output logic      [1:0]                  rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	// System clock pin function level
	input  wire logic                        system_clock_pin_function,
	// Shared pin
	input  wire logic                        divided_clock_pin_in,
	output logic                             divided_clock_pin_out,
	output logic                             divided_clock_pin_oe
);
	// ***************************************************
	// Declarations
	// ***************************************************
	logic                        aw_held_reg;
	logic [pco_pkg::ADDR_W-1:0]  awaddr_reg;
	logic                        w_held_reg;
	logic [31:0]                 wdata_reg;
	logic [3:0]                  wstrb_reg;
	logic                        wr_fire;
	pco_pkg::pco_sel_t           wr_sel;
	pco_pkg::pco_sel_t           rd_sel;
	logic                        en_reg;
	logic                        ss_reg;
	logic [pco_pkg::RV_W-1:0]    rv_reg;
	pco_pkg::pco_port_t          port_reg;
	pco_pkg::pco_sw_t            sw;
	pco_pkg::pco_ctrl_t          ctrl_word;
	pco_pkg::pco_port_t          port_word;
	logic [pco_pkg::RV_W-1:0]    cnt;
	logic                        tl;
	logic                        running;
	logic                        gen_out;
	logic                        gen_owns_pin;

	// Protection bits are accepted and ignored
	logic                        prot_unused;
	assign prot_unused = ^{awprot, arprot};

	function automatic pco_pkg::pco_sel_t decode(input logic [pco_pkg::ADDR_W-1:0] a);
		if (a == pco_pkg::CTRL_ADDR)
			return pco_pkg::SEL_CTRL;
		else if (a == pco_pkg::PORT_ADDR)
			return pco_pkg::SEL_PORT;
		else
			return pco_pkg::SEL_NONE;
	endfunction

	// ***************************************************
	// Write channels
	// ***************************************************
	// Address and data are held separately so either may come first
	assign awready = !aw_held_reg && !bvalid;
	assign wready  = !w_held_reg && !bvalid;
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid;
	assign wr_sel  = decode(awaddr_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			awaddr_reg  <= '0;
		end else if (awvalid && awready) begin
			aw_held_reg <= 1'b1;
			awaddr_reg  <= awaddr;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			wdata_reg  <= '0;
			wstrb_reg  <= '0;
		end else if (wvalid && wready) begin
			w_held_reg <= 1'b1;
			wdata_reg  <= wdata;
			wstrb_reg  <= wstrb;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= pco_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			if (wr_sel == pco_pkg::SEL_NONE)
				bresp <= pco_pkg::RESP_SLVERR;
			else
				bresp <= pco_pkg::RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ***************************************************
	// Control and port registers
	// ***************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_reg <= pco_pkg::CTRL_RESET.output_gen_enable;
			ss_reg <= pco_pkg::CTRL_RESET.output_signal_select;
			rv_reg <= pco_pkg::CTRL_RESET.divider_reload_value;
		end else if (wr_fire && wr_sel == pco_pkg::SEL_CTRL
				&& wstrb_reg[pco_pkg::CTRL_HI_LANE]) begin
			en_reg <= wdata_reg[15];
			ss_reg <= wdata_reg[14];
			rv_reg <= wdata_reg[13:8];
		end
	end

	// Counter and latch live in the divider; the low byte lane writes them there
	always_comb begin
		sw.cnt_we = wr_fire && wr_sel == pco_pkg::SEL_CTRL
			&& wstrb_reg[pco_pkg::CTRL_LO_LANE];
		sw.tl_we  = sw.cnt_we;
		sw.cnt    = wdata_reg[5:0];
		sw.tl     = wdata_reg[6];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_reg <= pco_pkg::PORT_RESET;
		end else if (wr_fire && wr_sel == pco_pkg::SEL_PORT
				&& wstrb_reg[pco_pkg::PORT_LANE]) begin
			port_reg.shared_port_bit       <= wdata_reg[0];
			port_reg.shared_port_direction <= wdata_reg[1];
			port_reg.sysclk_select         <= wdata_reg[2];
			port_reg.pin_level             <= 1'b0;
		end
	end

	always_comb begin
		ctrl_word.output_gen_enable    = en_reg;
		ctrl_word.output_signal_select = ss_reg;
		ctrl_word.divider_reload_value = rv_reg;
		ctrl_word.reserved             = 1'b0;
		ctrl_word.divider_toggle_latch = tl;
		ctrl_word.divider_counter      = cnt;
		port_word           = port_reg;
		port_word.pin_level = divided_clock_pin_in;
	end

	// ***************************************************
	// Read channel
	// ***************************************************
	assign arready = !rvalid;
	assign rd_sel  = decode(araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= pco_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= pco_pkg::RESP_OKAY;
			if (rd_sel == pco_pkg::SEL_CTRL)
				rdata <= {16'h0000, ctrl_word};
			else if (rd_sel == pco_pkg::SEL_PORT)
				rdata <= {28'h0000000, port_word};
			else begin
				rdata <= '0;
				rresp <= pco_pkg::RESP_SLVERR;
			end
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ***************************************************
	// Divider and pin
	// ***************************************************
	pco_divider pco_divider_inst (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.en                   (en_reg),
		.ss                   (ss_reg),
		.rv                   (rv_reg),
		.sw                   (sw),
		.divider_counter      (cnt),
		.divider_toggle_latch (tl),
		.running              (running),
		.gen_out              (gen_out)
	);

	// Generator keeps the pin until its last high pulse ends, then the latch takes over
	assign gen_owns_pin = en_reg || running;

	always_comb begin
		if (port_reg.sysclk_select)
			divided_clock_pin_out = system_clock_pin_function;
		else if (gen_owns_pin)
			divided_clock_pin_out = gen_out;
		else
			divided_clock_pin_out = port_reg.shared_port_bit;
	end

	// Pin is driven only when software turns the direction to output
	assign divided_clock_pin_oe = port_reg.shared_port_direction;

	// ***************************************************
	// Checks
	// ***************************************************
	default clocking dcb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Cycles since the last reload and the value loaded then, for the period check
	logic [pco_pkg::RV_W:0]   since_reload;
	logic [pco_pkg::RV_W-1:0] rv_loaded;
	always_ff @(posedge aclk) begin
		if (!aresetn || !running || cnt == '0 || $rose(en_reg))
			since_reload <= '0;
		else
			since_reload <= since_reload + 7'h01;
	end

	// A reload value written mid-period only counts from the next reload on
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rv_loaded <= '0;
		else if (!running || cnt == '0 || $rose(en_reg))
			rv_loaded <= rv_reg;
	end

	a_start_reload: assert property (
		$rose(en_reg) && !running |=> running && cnt == $past(rv_reg))
		else $error("enable rise did not load reload value");

	a_stop_low: assert property (
		running && !en_reg && !ss_reg && !tl |=> !running)
		else $error("generator did not halt at low level");

	a_stop_wait: assert property (
		running && !en_reg && !ss_reg && tl && cnt != '0 |=> running)
		else $error("generator halted during high phase");

	a_reload_val: assert property (
		running && cnt == '0 && !$rose(en_reg) |=> cnt == $past(rv_reg))
		else $error("underflow did not reload counter");

	a_toggle_flip: assert property (
		running && cnt == '0 && !$rose(en_reg) |=> tl != $past(tl))
		else $error("underflow did not toggle latch");

	a_latch_path: assert property (
		running && !ss_reg && !port_reg.sysclk_select
		|-> divided_clock_pin_out == tl)
		else $error("pin does not follow toggle latch");

	a_gate_pin: assert property (
		!running && !en_reg && !port_reg.sysclk_select
		|-> divided_clock_pin_out == port_reg.shared_port_bit)
		else $error("idle pin not from port latch");

	a_period_len: assert property (
		running && cnt == '0 && $past(running, 1)
		&& $past(cnt, 1) != '0 |-> since_reload == {1'b0, rv_loaded})
		else $error("period length differs from reload value plus one");

	a_raw_pulse: assert property (
		running && ss_reg && rv_reg != '0 && !port_reg.sysclk_select
		|-> divided_clock_pin_out == (cnt == '0))
		else $error("raw output not one cycle high");

	a_sysclk_prio: assert property (
		port_reg.sysclk_select |-> divided_clock_pin_out == system_clock_pin_function)
		else $error("system clock function lost priority");

	a_pin_dir: assert property (
		divided_clock_pin_oe == port_reg.shared_port_direction)
		else $error("pin enable differs from direction bit");

	a_count_down: assert property (
		running && cnt != '0 && !$rose(en_reg) |=> cnt == $past(cnt) - pco_pkg::CNT_ONE)
		else $error("counter did not decrement");

	a_reset_zero: assert property (
		@(posedge aclk) disable iff (1'b0)
		!$past(aresetn) |-> ctrl_word == pco_pkg::CTRL_RESET && !running)
		else $error("control not zero after reset");

	a_bresp_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before ready");

	a_rdata_hold: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data dropped before ready");

	a_write_block: assert property (
		bvalid |-> !awready && !wready)
		else $error("write channel open while response pending");

	c_start_stop: cover property (
		$rose(en_reg) ##[1:200] $fell(running));

	c_raw_clock: cover property (
		running && ss_reg && rv_reg == '0);

	c_sysclk_over: cover property (
		port_reg.sysclk_select && running);

	c_bad_addr: cover property (
		bvalid && bresp == pco_pkg::RESP_SLVERR);
endmodule
`default_nettype wire

// ### core/pco_divider.sv
`default_nettype none
module pco_divider (
	// Clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// Control fields
	input  wire logic                     en,
	input  wire logic                     ss,
	input  wire logic [pco_pkg::RV_W-1:0] rv,
	input  wire pco_pkg::pco_sw_t         sw,
	// Divider state and generated signal
	output logic      [pco_pkg::RV_W-1:0] divider_counter,
	output logic                          divider_toggle_latch,
	output logic                          running,
	output logic                          gen_out
);
	pco_pkg::pco_gen_t state_reg;
	pco_pkg::pco_gen_t state_next;
	logic              en_d_reg;
	logic              start;
	logic              uflow;
	logic              level;
	logic              cnt_zero;

	assign start    = en && !en_d_reg;
	assign running  = state_reg != pco_pkg::GEN_IDLE;
	assign cnt_zero = divider_counter == '0;
	assign uflow    = running && !start && cnt_zero;
	// Raw mode with reload zero has a low phase every cycle, so it may stop at once
	assign level    = ss ? (cnt_zero && rv != '0) : divider_toggle_latch;
	// Reload zero in raw mode passes the CPU clock itself
	assign gen_out  = running && (ss ? (rv == '0 ? aclk : cnt_zero) : divider_toggle_latch);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pco_pkg::GEN_IDLE: begin
				if (start)
					state_next = pco_pkg::GEN_RUN;
			end
			pco_pkg::GEN_RUN: begin
				if (!en)
					state_next = level ? pco_pkg::GEN_DRAIN : pco_pkg::GEN_IDLE;
			end
			pco_pkg::GEN_DRAIN: begin
				if (start)
					state_next = pco_pkg::GEN_RUN;
				else if (!level)
					state_next = pco_pkg::GEN_IDLE;
			end
			default: state_next = pco_pkg::GEN_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			state_reg <= pco_pkg::GEN_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			en_d_reg <= 1'b0;
		else
			en_d_reg <= en;
	end

	// Hardware updates win over a software write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			divider_counter <= pco_pkg::CTRL_RESET.divider_counter;
		else if (start)
			divider_counter <= rv;
		else if (uflow)
			divider_counter <= rv;
		else if (running)
			divider_counter <= divider_counter - pco_pkg::CNT_ONE;
		else if (sw.cnt_we)
			divider_counter <= sw.cnt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			divider_toggle_latch <= pco_pkg::CTRL_RESET.divider_toggle_latch;
		else if (uflow)
			divider_toggle_latch <= !divider_toggle_latch;
		else if (sw.tl_we)
			divider_toggle_latch <= sw.tl;
	end
endmodule
`default_nettype wire

// ### core/pco_pkg.sv
`default_nettype none
package pco_pkg;
	// ***************************************************
	// Register map (index as printed, byte address = 4 x index)
	// ***************************************************
	localparam int              ADDR_W    = 18;
	localparam logic [15:0]     CTRL_IDX  = 16'hffaa;
	localparam logic [15:0]     PORT_IDX  = 16'hffac;
	localparam logic [17:0]     CTRL_ADDR = {CTRL_IDX, 2'b00};
	localparam logic [17:0]     PORT_ADDR = {PORT_IDX, 2'b00};
	localparam logic [1:0]      RESP_OKAY   = 2'h0;
	localparam logic [1:0]      RESP_SLVERR = 2'h2;
	localparam int              CTRL_HI_LANE = 1;
	localparam int              CTRL_LO_LANE = 0;
	localparam int              PORT_LANE    = 0;

	// ***************************************************
	// Field layouts
	// ***************************************************
	localparam int              RV_W    = 6;
	localparam logic [RV_W-1:0] CNT_ONE = 6'h01;

	typedef struct packed {
		logic            output_gen_enable;
		logic            output_signal_select;
		logic [RV_W-1:0] divider_reload_value;
		logic            reserved;
		logic            divider_toggle_latch;
		logic [RV_W-1:0] divider_counter;
	} pco_ctrl_t;

	typedef struct packed {
		logic pin_level;
		logic sysclk_select;
		logic shared_port_direction;
		logic shared_port_bit;
	} pco_port_t;

	// Software write of the counter and toggle latch fields
	typedef struct packed {
		logic            cnt_we;
		logic [RV_W-1:0] cnt;
		logic            tl_we;
		logic            tl;
	} pco_sw_t;

	localparam pco_ctrl_t CTRL_RESET = 16'h0000;
	localparam pco_port_t PORT_RESET = 4'h0;

	typedef enum logic [1:0] {SEL_NONE, SEL_CTRL, SEL_PORT} pco_sel_t;
	typedef enum logic [1:0] {GEN_IDLE, GEN_RUN, GEN_DRAIN} pco_gen_t;
endpackage
`default_nettype wire

// ### tb/pco_pin_partner.sv
`default_nettype none
module pco_pin_partner (
	// Clock
	input  wire logic aclk,
	// Pin
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      pin_level,
	// Measurements
	output int        rises,
	output int        period,
	output int        high_len
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_q = 1'b0;
	logic prev   = 1'b0;
	int   since  = 0;
	int   hi_run = 0;
	// ***************************************************
	// Released pin shows a changing pattern, never the last level
	// ***************************************************
	assign pin_level = pin_oe ? pin_out : ~last_q;
	always @(posedge aclk) last_q <= pin_level;
	initial begin
		rises = 0;
		period = 0;
		high_len = 0;
	end
	// Sampled a little after both edges, so counts are in half cycles
	// and a pin that carries the clock itself still shows its pulses
	always begin
		@(aclk);
		#5;
		prev <= pin_level;
		if (pin_level)
			hi_run <= hi_run + 1;
		if (pin_level && !prev) begin
			rises <= rises + 1;
			period <= since;
			since <= 1;
			hi_run <= 1;
		end else
			since <= since + 1;
		if (!pin_level && prev)
			high_len <= hi_run;
	end
endmodule
`default_nettype wire

// ### tb/programmable_clock_output_tb.sv
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module programmable_clock_output_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0;
	logic        aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, sys_fn, pin_out, pin_oe, pin_lvl;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d1, d2;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [6:0]  rv;
	logic        sel;
	int          rises, period, high_len, bad_count, comparisons, r0;
	always #12.5 aclk = ~aclk;
	pco_clock_output pco_clock_output_inst (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.system_clock_pin_function(sys_fn), .divided_clock_pin_in(pin_lvl),
		.divided_clock_pin_out(pin_out), .divided_clock_pin_oe(pin_oe));
	pco_pin_partner pco_pin_partner_inst (.aclk(aclk), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_level(pin_lvl), .rises(rises), .period(period),
		.high_len(high_len));
	// ***************************************************
	// Bus tasks
	// ***************************************************
	task automatic close_out();
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic axi_write(input logic [17:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (1) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
				break;
			n++;
			if (n > 100) begin
				bad_count++;
				close_out();
			end
		end
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [17:0] a, output logic [31:0] d,
		output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (1) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
				break;
			n++;
			if (n > 100) begin
				bad_count++;
				close_out();
			end
		end
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		#2;
	endtask
	// ***************************************************
	// Test sequence
	// ***************************************************
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, sys_fn} = 7'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
		bad_count = 0;
		comparisons = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(pco_pkg::CTRL_ADDR, d1, r);
		`CHK(d1, 32'h00000000)
		`CHK(r, pco_pkg::RESP_OKAY)
		axi_read(18'h00010, d1, r);
		`CHK({d1, r}, {32'h00000000, pco_pkg::RESP_SLVERR})
		axi_write(18'h00010, 32'h0000ffff, 4'hf, r);
		`CHK(r, pco_pkg::RESP_SLVERR)
		// Port latch, direction and system clock priority
		axi_write(pco_pkg::PORT_ADDR, 32'h00000002, 4'h1, r);
		settle(1);
		`CHK({pin_oe, pin_out}, 2'b10)
		axi_write(pco_pkg::PORT_ADDR, 32'h00000003, 4'h1, r);
		settle(1);
		`CHK(pin_out, 1'b1)
		axi_read(pco_pkg::PORT_ADDR, d1, r);
		`CHK(d1, 32'h0000000b)
		axi_write(pco_pkg::PORT_ADDR, 32'h00000007, 4'h1, r);
		axi_write(pco_pkg::CTRL_ADDR, 32'h00008100, 4'h2, r);
		for (int i = 0; i < 6; i++) begin
			@(posedge aclk) sys_fn <= i[0];
			settle(1);
			`CHK(pin_out, i[0])
		end
		axi_write(pco_pkg::PORT_ADDR, 32'h00000003, 4'h1, r);
		settle(1);
		r0 = rises;
		settle(20);
		`CHK(rises - r0 > 3, 1'b1)
		axi_write(pco_pkg::PORT_ADDR, 32'h00000002, 4'h1, r);
		// Period and high time over select and reload values
		for (int i = 0; i < 5; i++) begin
			sel = i[0];
			rv = (i == 0) ? 7'd3 : (i == 1) ? 7'd1 : (i == 2) ? 7'd63 : (i == 3) ? 7'd0 : 7'd4;
			axi_write(pco_pkg::CTRL_ADDR, {16'h0, 1'b1, sel, rv[5:0], 8'h00}, 4'h2, r);
			settle(3 * (rv + 1) * 2 + 10);
			`CHK(period, 2 * (rv + 1) * (sel ? 1 : 2))
			`CHK(high_len, sel ? ((rv == 0) ? 1 : 2) : 2 * (rv + 1))
			axi_read(pco_pkg::CTRL_ADDR, d1, r);
			`CHK(d1[15:8], {1'b1, sel, rv[5:0]})
		end
		// Stop halts with the pin low and only whole pulses
		axi_write(pco_pkg::CTRL_ADDR, 32'h00000400, 4'h2, r);
		settle(20);
		r0 = rises;
		axi_read(pco_pkg::CTRL_ADDR, d1, r);
		settle(30);
		axi_read(pco_pkg::CTRL_ADDR, d2, r);
		`CHK(d1, d2)
		`CHK(rises, r0)
		`CHK(pin_out, 1'b0)
		`CHK(high_len, 2 * (rv + 1))
		// Toggle latch is writable while stopped
		axi_write(pco_pkg::CTRL_ADDR, 32'h00000040, 4'h1, r);
		axi_read(pco_pkg::CTRL_ADDR, d1, r);
		`CHK(d1, 32'h00000440)
		close_out();
	end
	initial begin
		#2ms;
		bad_count++;
		close_out();
	end
endmodule
`default_nettype wire
